// ### design/urxp_port.v
// Receive word port: queue of received characters read over APB.
// Assumes a receiver on ref_clk delivering one-cycle character strobes.
`timescale 1ns/1ps
`include "urxp_map.vh"

// Operation
// RULE1 - read-only port, character plus status flags
// RULE2 - sixteen word aliases all return port
// RULE3 - valid flag zero until first character
// RULE4 - upper sixteen bits always read zero
// RULE5 - valid set; empty read returns stale, cleared
// RULE6 - error summary ORs the four faults
// RULE7 - full queue drops new, flags last stored
// RULE8 - overrun on 32nd entry, drop until read
// RULE9 - software must keep pace with data
// RULE10 - framing flag for missing stop bit
// RULE11 - break sets framing, parity if odd
// RULE12 - parity flag, zero when parity disabled
// RULE13 - data low byte, bit 7 zero seven-bit
// RULE14 - each non-empty read pops one entry
module urxp_port (
   ref_clk, // Peripheral clock, 100 MHz
   rst_n, // Synchronous reset, active low
   psel, // APB select
   penable, // APB enable
   pwrite, // APB direction
   paddr, // APB address
   pwdata, // APB write data
   prdata, // APB read data
   pready, // APB ready
   pslverr, // APB error
   rx_strobe, // Receiver character strobe
   rx_char, // Receiver character
   rx_stop_bad, // Stop bit missing
   rx_par_bad, // Parity mismatch seen
   irq // Level interrupt
);
   input wire ref_clk; // Clock
   input wire rst_n; // Reset
   input wire psel; // Select
   input wire penable; // Enable
   input wire pwrite; // Write
   input wire [31:0] paddr; // Address
   input wire [31:0] pwdata; // Write data
   output reg [31:0] prdata; // Read data
   output reg pready; // Ready
   output reg pslverr; // Error
   input wire rx_strobe; // Char strobe
   input wire [7:0] rx_char; // Char bits
   input wire rx_stop_bad; // Framing fault
   input wire rx_par_bad; // Parity fault
   output reg irq; // Interrupt

   // ==========================================================
   // Registers
   reg [3:0] ctrl_q; // Receiver on, parity enable, odd, eight-bit
   reg [`URXP_IRQ_W-1:0] ist_q; // Sticky interrupt status
   reg [`URXP_IRQ_W-1:0] imask_q; // Interrupt mask
   reg [15:0] last_q; // Last word returned, replayed when empty
   reg valid_q; // Any character ever read out since reset
   reg dropping_q; // Queue full, new characters dropped

   // ==========================================================
   // Access decode
   wire setup = psel && !penable; // First cycle of a transfer
   wire hit_port = (paddr & `URXP_ALIAS_MASK) == `URXP_BASE_ADDR; // [RULE2]
   wire hit_ist = paddr == `URXP_IRQ_STAT_ADDR;
   wire hit_imask = paddr == `URXP_IRQ_MASK_ADDR;
   wire hit_ctrl = paddr == `URXP_CTRL_ADDR;
   wire hit_any = hit_port || hit_ist || hit_imask || hit_ctrl;
   // Action happens once, at the setup cycle; the answer follows next edge
   wire rd_port = setup && !pwrite && hit_port;
   wire wr_ok = setup && pwrite;

   // ==========================================================
   // Character formation from the receiver
   wire [`URXP_ENTRY_W-1:0] head;
   wire [`URXP_CNT_W-1:0] level;
   wire q_empty = level == {`URXP_CNT_W{1'b0}};
   wire q_full = level == `URXP_FULL_CNT;
   wire is_brk = rx_char == 8'h00 && rx_stop_bad; // Data and stop all zero [RULE11]
   wire [7:0] data_in = ctrl_q[`URXP_CTRL_EIGHT] ? rx_char :
      {1'b0, rx_char[6:0]}; // [RULE13]
   wire frm_in = rx_stop_bad || is_brk; // [RULE10] [RULE11]
   wire par_in = ctrl_q[`URXP_CTRL_PAREN] &&
      (rx_par_bad || (is_brk && ctrl_q[`URXP_CTRL_ODD])); // [RULE12] [RULE11]
   wire take = rx_strobe && ctrl_q[`URXP_CTRL_RXON];
   wire pop = rd_port && !q_empty; // [RULE14]
   // A full queue is always dropping, so a pop in the same cycle does not save the char
   wire room = !dropping_q && (!q_full || pop);
   wire push = take && room; // Full queue never overwrites [RULE7]
   // Overrun marks the entry that leaves 32 held, a pop in the same cycle included [RULE8]
   wire ovr_in = pop ? q_full : (level == `URXP_LAST_CNT);
   wire [`URXP_ENTRY_W-1:0] entry = {ovr_in, frm_in, is_brk, par_in, 1'b0, data_in};

   urxp_queue u_queue (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .push(push),
      .push_data(entry),
      .pop(pop),
      .head_data(head),
      .count(level)
   );

   // Word presented for the oldest entry; summary bit rebuilt per char
   wire h_ovr = head[12];
   wire h_frm = head[11];
   wire h_brk = head[10];
   wire h_par = head[9];
   wire h_err = h_ovr || h_frm || h_brk || h_par; // [RULE6]
   wire [15:0] fresh_word;
   assign fresh_word = {1'b1, h_err, h_ovr, h_frm, h_brk, h_par, 2'b00,
      head[7:0]}; // [RULE5]

   // ==========================================================
   // Stale word: same bits, valid flag cleared
   wire [15:0] stale_word = last_q & ~(16'h0001 << `URXP_VALID_BIT); // [RULE5]

   // ==========================================================
   // Last word and drop state
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         last_q <= 16'h0000; // Valid flag reads zero until a char [RULE3]
         valid_q <= 1'b0;
         dropping_q <= 1'b0;
      end else begin
         if (pop) begin
            last_q <= fresh_word; // [RULE14]
            valid_q <= 1'b1;
         end
         // Dropping ends with a read, starts when the last place fills
         if (pop) begin
            dropping_q <= 1'b0; // [RULE8]
         end else if (push && ovr_in) begin
            dropping_q <= 1'b1; // [RULE8]
         end
      end
   end

   // ==========================================================
   // Control, mask and sticky status; set wins over clear
   wire [`URXP_IRQ_W-1:0] ev;
   assign ev = {push && (frm_in || par_in || ovr_in), push && ovr_in, push};
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= `URXP_CTRL_RESET;
         imask_q <= {`URXP_IRQ_W{1'b0}};
         ist_q <= {`URXP_IRQ_W{1'b0}};
      end else begin
         if (wr_ok && hit_ctrl) begin
            ctrl_q <= pwdata[3:0];
         end
         if (wr_ok && hit_imask) begin
            imask_q <= pwdata[`URXP_IRQ_W-1:0];
         end
         if (wr_ok && hit_ist) begin
            ist_q <= (ist_q & ~pwdata[`URXP_IRQ_W-1:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
      end
   end

   // ==========================================================
   // APB answer: registered, one cycle after setup
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         prdata <= `URXP_ZERO32;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq <= |(ist_q & imask_q);
         pready <= setup;
         // Unmapped address, or a write to the read-only port [RULE1]
         pslverr <= setup && (!hit_any || (pwrite && hit_port));
         if (setup && !pwrite) begin
            if (hit_port) begin
               // Upper half always zero [RULE4]
               prdata <= {16'h0000, q_empty ? stale_word : fresh_word};
            end else if (hit_ist) begin
               prdata <= {{(32-`URXP_IRQ_W){1'b0}}, ist_q};
            end else if (hit_imask) begin
               prdata <= {{(32-`URXP_IRQ_W){1'b0}}, imask_q};
            end else if (hit_ctrl) begin
               prdata <= {28'h0000000, ctrl_q};
            end else begin
               prdata <= `URXP_ZERO32;
            end
         end else if (!setup) begin
            prdata <= `URXP_ZERO32;
         end
      end
   end
endmodule // urxp_port

// ### design/urxp_map.vh
// Constants for the receive word port: offsets, field positions, sizes.
// Assumes inclusion by the port logic and the queue; holds definitions only.
`ifndef URXP_MAP_VH
`define URXP_MAP_VH

// ==========================================================
// Address decode
`define URXP_BASE_ADDR 32'h00206000
`define URXP_ALIAS_MASK 32'hffffffc3
`define URXP_IRQ_STAT_ADDR 32'h00206100
`define URXP_IRQ_MASK_ADDR 32'h00206104
`define URXP_CTRL_ADDR 32'h00206108

// ==========================================================
// Field positions of the receive word
`define URXP_VALID_BIT 15
`define URXP_ERR_BIT 14
`define URXP_OVR_BIT 13
`define URXP_FRM_BIT 12
`define URXP_BRK_BIT 11
`define URXP_PAR_BIT 10
`define URXP_MSB_BIT 7

// ==========================================================
// Control register bits
`define URXP_CTRL_RXON 0
`define URXP_CTRL_PAREN 1
`define URXP_CTRL_ODD 2
`define URXP_CTRL_EIGHT 3
`define URXP_CTRL_RESET 4'h0

// ==========================================================
// Interrupt status bits
`define URXP_IRQ_AVAIL 0
`define URXP_IRQ_OVR 1
`define URXP_IRQ_ERR 2
`define URXP_IRQ_W 3

// ==========================================================
// Queue geometry
`define URXP_DEPTH 32
`define URXP_PTR_W 5
`define URXP_CNT_W 6
`define URXP_ENTRY_W 13
`define URXP_ZERO32 32'h00000000
`define URXP_ONE_CNT 6'h01
`define URXP_ONE_PTR 5'h01
`define URXP_FULL_CNT 6'h20
`define URXP_LAST_CNT 6'h1f

`endif

// ### design/urxp_queue.v
// Receive queue storage: 32 entries of character plus flags.
// Assumes the caller never pushes when full and never pops when empty.
`timescale 1ns/1ps
`include "urxp_map.vh"

module urxp_queue (
   ref_clk, // Peripheral clock
   rst_n, // Synchronous reset, active low
   push, // Store one entry
   push_data, // Entry to store
   pop, // Remove oldest entry
   head_data, // Oldest entry
   count // Entries held
);
   input wire ref_clk; // Peripheral clock
   input wire rst_n; // Reset
   input wire push; // Store strobe
   input wire [`URXP_ENTRY_W-1:0] push_data; // Data in
   input wire pop; // Remove strobe
   output wire [`URXP_ENTRY_W-1:0] head_data; // Data out
   output wire [`URXP_CNT_W-1:0] count; // Fill level

   // Storage array, no reset needed on data
   reg [`URXP_ENTRY_W-1:0] mem [0:`URXP_DEPTH-1];
   reg [`URXP_PTR_W-1:0] wr_q; // Write pointer
   reg [`URXP_PTR_W-1:0] rd_q; // Read pointer
   reg [`URXP_CNT_W-1:0] cnt_q; // Level

   assign head_data = mem[rd_q];
   assign count = cnt_q;

   // ==========================================================
   // Write side
   always @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= push_data;
      end
   end

   // ==========================================================
   // Pointers and level
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_q <= {`URXP_PTR_W{1'b0}};
         rd_q <= {`URXP_PTR_W{1'b0}};
         cnt_q <= {`URXP_CNT_W{1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + `URXP_ONE_PTR;
         end
         if (pop) begin
            rd_q <= rd_q + `URXP_ONE_PTR;
         end
         // Simultaneous push and pop leaves the level alone
         if (push && !pop) begin
            cnt_q <= cnt_q + `URXP_ONE_CNT;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - `URXP_ONE_CNT;
         end
      end
   end
endmodule // urxp_queue

// ### test/urxp_port_checker.sv
// Concurrent checks on the receive word port, bound to urxp_port.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module urxp_port_checker (
   input wire ref_clk, // Clock
   input wire rst_n, // Reset
   input wire psel, // Select
   input wire penable, // Enable
   input wire pwrite, // Write
   input wire [31:0] paddr, // Address
   input wire [31:0] prdata, // Read data
   input wire pready, // Ready
   input wire pslverr, // Error
   input wire rx_strobe // Char strobe
);
   // ==========================================================
   // Helper logic
   reg seen_q; // Some character offered since reset
   wire hit = psel && !penable && (paddr & 32'hffffffc3) == 32'h00206000; // Port setup
   // Conservative: a strobe with the receiver off still counts
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else if (rx_strobe) begin
         seen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Properties
   property p_ro; hit && pwrite |=> pready && pslverr; endproperty
   a_ro: assert property (p_ro) else $error("port write not refused");
   property p_alias; hit && !pwrite |=> pready && !pslverr; endproperty
   a_alias: assert property (p_alias) else $error("alias read not served");
   property p_first; pready && !seen_q |-> !prdata[15]; endproperty
   a_first: assert property (p_first) else $error("valid before any char");
   property p_top; pready |-> prdata[31:16] == 16'h0000; endproperty
   a_top: assert property (p_top) else $error("upper half not zero");
   property p_rsv; pready |-> prdata[9:8] == 2'b00; endproperty
   a_rsv: assert property (p_rsv) else $error("bits 9:8 not zero");
   property p_err; pready |-> prdata[14] == (|prdata[13:10]); endproperty
   a_err: assert property (p_err) else $error("error summary wrong");
   property p_brk; pready && prdata[11] |-> prdata[12]; endproperty
   a_brk: assert property (p_brk) else $error("break without framing");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("answer longer than a cycle");
   c_valid: cover property (pready && prdata[15]);
   c_ovr: cover property (pready && prdata[13]);
   c_brk: cover property (pready && prdata[11]);
endmodule // urxp_port_checker

bind urxp_port urxp_port_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_strobe(rx_strobe));

// ### test/urxp_rx_model.sv
// Serial receiver stand-in: hands one character per strobe to the port.
// Assumes the same clock as the port; strobes are one cycle wide.
`timescale 1ns/1ps
module urxp_rx_model (
   input wire ref_clk, // Clock
   output logic rx_strobe, // Char strobe
   output logic [7:0] rx_char, // Char bits
   output logic rx_stop_bad, // Framing fault
   output logic rx_par_bad // Parity fault
);
   // ==========================================================
   // Idle state: data lines show junk so stale values never match
   initial begin
      rx_strobe = 1'b0;
      rx_char = 8'h5a;
      rx_stop_bad = 1'b1;
      rx_par_bad = 1'b1;
   end
   // One character, then the lines are inverted once the strobe ends
   task send(input logic [7:0] c, input logic fb, input logic pb);
      @(posedge ref_clk);
      rx_strobe <= 1'b1;
      rx_char <= c;
      rx_stop_bad <= fb;
      rx_par_bad <= pb;
      @(posedge ref_clk);
      rx_strobe <= 1'b0;
      rx_char <= ~c;
      rx_stop_bad <= ~fb;
      rx_par_bad <= ~pb;
   endtask
endmodule // urxp_rx_model

// ### test/urxp_port_tb_top.sv
// Self-checking bench for the receive word port over APB.
// Assumes urxp_port, the rx model and the checker are compiled first.
`timescale 1ns/1ps
module urxp_port_tb_top;
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq; // Bus and irq
   logic [31:0] paddr, pwdata, prdata; // Bus words
   wire rx_strobe, rx_stop_bad, rx_par_bad; // Receiver side
   wire [7:0] rx_char; // Receiver char
   int err_total = 0; // Mismatches
   int tests_run = 0; // Comparisons
   localparam logic [31:0] port_a = 32'h00206000; // Port base
   // Flagged-character table: ctrl, char, stop bad, parity bad, expected word
   logic [3:0] t_ctl [6] = '{4'h9, 4'hb, 4'h9, 4'hf, 4'hb, 4'h1};
   logic [7:0] t_chr [6] = '{8'h3c, 8'h41, 8'h41, 8'h00, 8'h00, 8'hff};
   logic [1:0] t_flt [6] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b00};
   logic [31:0] t_exp [6] = '{32'hd03c, 32'hc441, 32'h8041, 32'hdc00, 32'hd800, 32'h807f};
   urxp_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_strobe(rx_strobe), .rx_char(rx_char),
      .rx_stop_bad(rx_stop_bad), .rx_par_bad(rx_par_bad), .irq(irq));
   urxp_rx_model u_rx (.ref_clk(ref_clk), .rx_strobe(rx_strobe), .rx_char(rx_char),
      .rx_stop_bad(rx_stop_bad), .rx_par_bad(rx_par_bad));
   // ==========================================================
   // Shared tasks
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task acc(input logic w, input logic [31:0] a, d, exp, input logic ee);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // No assumed latency: only the watchdog ends a hung wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      if (!w) chk("rdata", exp, prdata);
      chk("slverr", {31'h0, ee}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task final_report;
      $display("Comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================================
   // Clock and watchdog; the run needs a few hundred cycles
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #200us;
      err_total++;
      final_report;
   end
   // ==========================================================
   // Test sequence
   initial begin
      {rst_n, psel, penable, pwrite} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      acc(1'b1, 32'h00206108, 32'h9, 32'h0, 1'b0);
      acc(1'b0, port_a, 32'h0, 32'h0, 1'b0);
      acc(1'b1, port_a + 32'h4, 32'h5, 32'h0, 1'b1);
      acc(1'b0, port_a + 32'h40, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 32'h00206104, 32'h1, 32'h0, 1'b0);
      u_rx.send(8'ha5, 1'b0, 1'b0);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", 32'h1, {31'h0, irq});
      acc(1'b0, 32'h00206100, 32'h0, 32'h1, 1'b0);
      acc(1'b0, port_a + 32'h3c, 32'h0, 32'h80a5, 1'b0);
      acc(1'b0, port_a + 32'h3c, 32'h0, 32'h00a5, 1'b0);
      acc(1'b1, 32'h00206100, 32'h1, 32'h0, 1'b0);
      #1 chk("irq", 32'h0, {31'h0, irq});
      acc(1'b1, 32'h00206104, 32'h0, 32'h0, 1'b0);
      // Receiver off: the character is ignored, the stale word comes back
      acc(1'b1, 32'h00206108, 32'h0, 32'h0, 1'b0);
      u_rx.send(8'h11, 1'b0, 1'b0);
      acc(1'b0, port_a, 32'h0, 32'h00a5, 1'b0);
      for (int i = 0; i < 6; i++) begin
         acc(1'b1, 32'h00206108, {28'h0, t_ctl[i]}, 32'h0, 1'b0);
         u_rx.send(t_chr[i], t_flt[i][1], t_flt[i][0]);
         #1 chk("irq", 32'h0, {31'h0, irq});
         acc(1'b0, port_a | {i[3:0], 2'b00}, 32'h0, t_exp[i], 1'b0);
      end
      acc(1'b1, 32'h00206108, 32'h9, 32'h0, 1'b0);
      // Software falls behind on purpose so the queue overflows
      for (int i = 0; i < 33; i++) u_rx.send(i[7:0], 1'b0, 1'b0);
      for (int i = 0; i < 32; i++) begin
         acc(1'b0, port_a | {i[3:0], 2'b00}, 32'h0, (i == 31) ? 32'he01f : 32'h8000 | i, 1'b0);
      end
      acc(1'b0, port_a, 32'h0, 32'h601f, 1'b0);
      u_rx.send(8'h77, 1'b0, 1'b0);
      acc(1'b0, port_a, 32'h0, 32'h8077, 1'b0);
      // Second reset in mid-run: the last word must be forgotten
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      acc(1'b1, 32'h00206108, 32'h9, 32'h0, 1'b0);
      acc(1'b0, port_a + 32'h8, 32'h0, 32'h0, 1'b0);
      final_report;
   end
endmodule // urxp_port_tb_top
